// ---- src/tfs_crc32.sv ----
// byte-wise reflected ethernet crc register
module tfs_crc32
   import tfs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic clkEn,
   input wire logic clear,
   input wire logic update,
   input wire logic [7:0] dataIn,
   output logic [31:0] crc
);
   logic [31:0] crc_reg;
   logic [31:0] crc_next;

   always_comb
   begin
      logic [31:0] c;
      c = crc_reg;
      crc_next = crc_reg;
      if (clear)
      begin
         crc_next = TFS_CRC_INIT;
      end
      else if (update)
      begin
         c = crc_reg ^ {24'h000000, dataIn};
         for (int i = 0; i < 8; i++)
         begin
            c = c[0] ? ((c >> 1) ^ TFS_CRC_POLY) : (c >> 1);
         end
         crc_next = c;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         crc_reg <= TFS_CRC_INIT;
      end
      else if (clkEn)
      begin
         crc_reg <= crc_next;
      end
   end

   assign crc = crc_reg;
endmodule : tfs_crc32

// ---- src/tfs_pkg.sv ----
// constants and types shared by the test frame source
package tfs_pkg;
   localparam logic [4:0] TFS_CTRL_ADDR = 5'h1c;
   localparam logic [4:0] TFS_PATTERN_ADDR = 5'h1d;
   localparam logic [15:0] TFS_CTRL_RESET = 16'h0000;
   localparam logic [15:0] TFS_PATTERN_RESET = 16'h00aa;
   // bits software may change in the control register; reserved bits read zero
   localparam logic [15:0] TFS_CTRL_WMASK = 16'h2f73;
   localparam int TFS_EN_BIT = 0;
   localparam int TFS_START_BIT = 1;
   localparam int TFS_SIZE_LSB = 4;
   localparam int TFS_TYPE_LSB = 8;
   localparam int TFS_GAP_LSB = 10;
   localparam int TFS_MODE_BIT = 13;
   localparam int TFS_DATA_LSB = 0;
   localparam int TFS_SRC_LSB = 8;
   localparam int TFS_DST_LSB = 12;
   localparam logic [1:0] TFS_TYPE_RANDOM = 2'h0;
   localparam logic [1:0] TFS_TYPE_INCREMENT = 2'h1;
   localparam logic [1:0] TFS_GAP_48 = 2'h0;
   localparam logic [1:0] TFS_GAP_96 = 2'h1;
   localparam int TFS_GAP_SHORT_BITS = 48;
   localparam int TFS_GAP_MID_BITS = 96;
   localparam int TFS_GAP_LONG_BITS = 9600;
   localparam int TFS_BITS_PER_BYTE = 8;
   localparam int TFS_ADDR_BYTES = 6;
   localparam int TFS_HEADER_BYTES = 14;
   localparam int TFS_FCS_BYTES = 4;
   localparam int TFS_BURST_FRAMES = 10000;
   localparam logic [31:0] TFS_CRC_INIT = 32'hffffffff;
   localparam logic [31:0] TFS_CRC_POLY = 32'hedb88320;
   localparam logic [31:0] TFS_LFSR_SEED = 32'h1234abcd;
   localparam logic [31:0] TFS_LFSR_POLY = 32'h80200003;
   localparam logic [7:0] TFS_ONES = 8'hff;
   localparam logic [3:0] TFS_NIBBLE_ONES = 4'hf;

   typedef enum logic [1:0] {TFS_IDLE, TFS_SEND, TFS_GAP} tfs_state_t;

   function automatic logic [13:0] tfs_frame_len(input logic [2:0] code);
      case (code)
         3'h0: tfs_frame_len = 14'h0040;
         3'h1: tfs_frame_len = 14'h0080;
         3'h2: tfs_frame_len = 14'h0100;
         3'h3: tfs_frame_len = 14'h0200;
         3'h4: tfs_frame_len = 14'h0400;
         3'h5: tfs_frame_len = 14'h05ee;
         default: tfs_frame_len = 14'h2580;
      endcase
   endfunction : tfs_frame_len
endpackage : tfs_pkg

// ---- src/tfs_test_frame_source.sv ----
// test frame generator with its two control registers
// What this block does
// - size code picks 64 to 9600 bytes
// - size covers addresses, type, payload and check
// - run bit one starts, zero halts
// - single sends one; burst repeats 10000-frame groups
// - enable bit zero means no frames
// - payload types other than random and incrementing use programmed pattern byte
// - destination nibble ends fixed destination address
// - source nibble ends fixed source address
// - mode bit zero burst, one single
// - type selects random, incrementing or programmed bytes
// - gap code gives 48, 96, 9600 bit times
module tfs_test_frame_source
   import tfs_pkg::*;
#(
   parameter logic [23:0] PREFIX_CODE = 24'h02a5c3, // arbitrary value, not a real maker code
   parameter int BURST_FRAMES = TFS_BURST_FRAMES
)
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic clkEn,
   input wire logic [4:0] regAddr,
   input wire logic regWrite,
   input wire logic [15:0] regWdata,
   output logic [15:0] regRdata,
   output logic [7:0] txData,
   output logic txValid,
   output logic txFirst,
   output logic txLast,
   output logic groupDone
);
   localparam logic [10:0] GAP_SHORT = 11'(TFS_GAP_SHORT_BITS / TFS_BITS_PER_BYTE);
   localparam logic [10:0] GAP_MID = 11'(TFS_GAP_MID_BITS / TFS_BITS_PER_BYTE);
   localparam logic [10:0] GAP_LONG = 11'(TFS_GAP_LONG_BITS / TFS_BITS_PER_BYTE);
   localparam logic [13:0] HDR = 14'(TFS_HEADER_BYTES);
   localparam logic [13:0] FCS = 14'(TFS_FCS_BYTES);
   localparam logic [13:0] OVERHEAD = 14'(TFS_HEADER_BYTES + TFS_FCS_BYTES);
   localparam logic [13:0] ADDR_BYTES = 14'(TFS_ADDR_BYTES);
   localparam logic [15:0] GROUP_LAST = 16'(BURST_FRAMES - 1);

   tfs_state_t state_reg, state_next;
   logic [15:0] ctrl_reg, ctrl_next;
   logic [15:0] pattern_reg, pattern_next;
   logic [15:0] rdata_reg, rdata_next;
   logic [13:0] idx_reg, idx_next;
   logic [13:0] len_reg, len_next;
   logic [10:0] gap_reg, gap_next;
   logic [15:0] group_reg, group_next;
   logic [31:0] lfsr_reg, lfsr_next;
   logic [7:0] data_reg, data_next;
   logic valid_reg, valid_next;
   logic first_reg, first_next;
   logic last_reg, last_next;
   logic done_reg, done_next;
   logic crcClear;
   logic crcUpdate;
   logic [31:0] crc;

   tfs_crc32 crcUnit (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .clkEn(clkEn),
      .clear(crcClear),
      .update(crcUpdate),
      .dataIn(data_next),
      .crc(crc)
   );

   always_comb
   begin
      logic runOk;
      logic singleMode;
      logic [13:0] payLen;
      logic [13:0] payIdx;
      logic [13:0] fcsIdx;
      logic [7:0] addrLow;
      logic [13:0] addrPos;
      runOk = ctrl_reg[TFS_EN_BIT] & ctrl_reg[TFS_START_BIT];
      singleMode = ctrl_reg[TFS_MODE_BIT];
      payLen = len_reg - OVERHEAD;
      payIdx = idx_reg - HDR;
      fcsIdx = idx_reg - (len_reg - FCS);
      addrLow = 8'h00;
      addrPos = 14'h0000;
      state_next = state_reg;
      ctrl_next = ctrl_reg;
      pattern_next = pattern_reg;
      idx_next = idx_reg;
      len_next = len_reg;
      gap_next = gap_reg;
      group_next = group_reg;
      lfsr_next = lfsr_reg[0] ? ((lfsr_reg >> 1) ^ TFS_LFSR_POLY) : (lfsr_reg >> 1);
      data_next = data_reg;
      valid_next = 1'b0;
      first_next = 1'b0;
      last_next = 1'b0;
      done_next = 1'b0;
      crcClear = 1'b0;
      crcUpdate = 1'b0;

      case (state_reg)
         TFS_IDLE:
         begin
            crcClear = 1'b1;
            idx_next = 14'h0000;
            if (runOk)
            begin
               len_next = tfs_frame_len(ctrl_reg[TFS_SIZE_LSB +: 3]);
               state_next = TFS_SEND;
            end
         end
         TFS_SEND:
         begin
            valid_next = 1'b1;
            first_next = (idx_reg == 14'h0000);
            if (idx_reg < ADDR_BYTES)
            begin
               addrLow = {TFS_NIBBLE_ONES, pattern_reg[TFS_DST_LSB +: 4]};
               addrPos = idx_reg;
            end
            else
            begin
               addrLow = {TFS_NIBBLE_ONES, pattern_reg[TFS_SRC_LSB +: 4]};
               addrPos = idx_reg - ADDR_BYTES;
            end
            if (idx_reg < 14'(2 * TFS_ADDR_BYTES))
            begin
               case (addrPos[2:0])
                  3'h0: data_next = PREFIX_CODE[23:16];
                  3'h1: data_next = PREFIX_CODE[15:8];
                  3'h2: data_next = PREFIX_CODE[7:0];
                  3'h3: data_next = TFS_ONES;
                  3'h4: data_next = TFS_ONES;
                  default: data_next = addrLow;
               endcase
               crcUpdate = 1'b1;
            end
            else if (idx_reg < HDR)
            begin
               // length field carries the payload length, big-endian
               data_next = (idx_reg == HDR - 14'h0002) ? {2'h0, payLen[13:8]} : payLen[7:0];
               crcUpdate = 1'b1;
            end
            else if (idx_reg < len_reg - FCS)
            begin
               case (ctrl_reg[TFS_TYPE_LSB +: 2])
                  TFS_TYPE_RANDOM: data_next = lfsr_reg[7:0];
                  TFS_TYPE_INCREMENT: data_next = payIdx[7:0];
                  default: data_next = pattern_reg[TFS_DATA_LSB +: 8];
               endcase
               crcUpdate = 1'b1;
            end
            else
            begin
               // crc frozen during the check bytes, sent low byte first
               data_next = ~crc[{fcsIdx[1:0], 3'h0} +: 8];
            end
            idx_next = idx_reg + 14'h0001;
            if (idx_reg == len_reg - 14'h0001)
            begin
               last_next = 1'b1;
               state_next = TFS_GAP;
               case (ctrl_reg[TFS_GAP_LSB +: 2])
                  TFS_GAP_48: gap_next = GAP_SHORT;
                  TFS_GAP_96: gap_next = GAP_MID;
                  default: gap_next = GAP_LONG;
               endcase
               if (singleMode)
               begin
                  ctrl_next[TFS_START_BIT] = 1'b0;
               end
               if (group_reg == GROUP_LAST)
               begin
                  group_next = 16'h0000;
                  done_next = 1'b1;
               end
               else
               begin
                  group_next = group_reg + 16'h0001;
               end
            end
         end
         TFS_GAP:
         begin
            crcClear = 1'b1;
            idx_next = 14'h0000;
            gap_next = gap_reg - 11'h001;
            if (gap_reg == 11'h001)
            begin
               state_next = TFS_IDLE;
               if (!singleMode && runOk)
               begin
                  len_next = tfs_frame_len(ctrl_reg[TFS_SIZE_LSB +: 3]);
                  state_next = TFS_SEND;
               end
            end
         end
         default:
         begin
            state_next = TFS_IDLE;
         end
      endcase

      if (!ctrl_reg[TFS_START_BIT] && !valid_next)
      begin
         group_next = 16'h0000;
      end

      // a software write lands after the hardware start clear, so it wins
      if (regWrite && regAddr == TFS_CTRL_ADDR)
      begin
         ctrl_next = regWdata & TFS_CTRL_WMASK;
      end
      if (regWrite && regAddr == TFS_PATTERN_ADDR)
      begin
         pattern_next = regWdata;
      end
      case (regAddr)
         TFS_CTRL_ADDR: rdata_next = ctrl_reg;
         TFS_PATTERN_ADDR: rdata_next = pattern_reg;
         default: rdata_next = 16'h0000;
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_reg <= TFS_IDLE;
         ctrl_reg <= TFS_CTRL_RESET;
         pattern_reg <= TFS_PATTERN_RESET;
         rdata_reg <= 16'h0000;
         idx_reg <= 14'h0000;
         len_reg <= 14'h0000;
         gap_reg <= 11'h000;
         group_reg <= 16'h0000;
         lfsr_reg <= TFS_LFSR_SEED;
         data_reg <= 8'h00;
         valid_reg <= 1'b0;
         first_reg <= 1'b0;
         last_reg <= 1'b0;
         done_reg <= 1'b0;
      end
      else if (clkEn)
      begin
         state_reg <= state_next;
         ctrl_reg <= ctrl_next;
         pattern_reg <= pattern_next;
         rdata_reg <= rdata_next;
         idx_reg <= idx_next;
         len_reg <= len_next;
         gap_reg <= gap_next;
         group_reg <= group_next;
         lfsr_reg <= lfsr_next;
         data_reg <= data_next;
         valid_reg <= valid_next;
         first_reg <= first_next;
         last_reg <= last_next;
         done_reg <= done_next;
      end
   end

   assign regRdata = rdata_reg;
   assign txData = data_reg;
   assign txValid = valid_reg;
   assign txFirst = first_reg;
   assign txLast = last_reg;
   assign groupDone = done_reg;
endmodule : tfs_test_frame_source

// ---- tb/test_tfs_test_frame_source.sv ----
// self-checking bench for the test frame source
module test_tfs_test_frame_source
   import tfs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 1'b0, reset_n = 1'b0, regWrite = 1'b0, pend = 1'b0, clkEn = 1'b1;
   logic [4:0] regAddr = 5'h00;
   logic [15:0] regWdata = 16'h0000, regRdata, frames, w, f0, gap = 16'h0000, lastGap;
   logic [15:0] nGroup = 16'h0000;
   logic [7:0] txData, pat, q[$];
   logic [3:0] dst, src;
   logic [2:0] sz;
   logic [1:0] typ;
   logic txValid, txFirst, txLast, groupDone, crcOk;
   int err_count = 0, n_tests = 0, cyc = 0;
   tfs_test_frame_source #(.BURST_FRAMES(3)) uut (.ref_clk(ref_clk), .reset_n(reset_n),
      .clkEn(clkEn), .regAddr(regAddr), .regWrite(regWrite), .regWdata(regWdata),
      .regRdata(regRdata), .txData(txData), .txValid(txValid), .txFirst(txFirst),
      .txLast(txLast), .groupDone(groupDone));
   tfs_tx_sink sink (.ref_clk(ref_clk), .reset_n(reset_n), .txData(txData),
      .txValid(txValid), .txFirst(txFirst), .txLast(txLast), .crcOk(crcOk), .frames(frames));
   initial forever #10 ref_clk = ~ref_clk;
   function automatic logic [15:0] flen(input logic [2:0] c);
      return c == 3'h6 ? 16'h2580 : c == 3'h5 ? 16'h05ee : 16'h0040 << c;
   endfunction : flen
   task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (e !== g)
      begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask : check
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop
   // extra edge after the strobe drops keeps writes apart
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      regAddr = a;
      regWdata = d;
      regWrite = 1'b1;
      @(negedge ref_clk);
      regWrite = 1'b0;
      @(negedge ref_clk);
   endtask : wr
   task automatic rd(input logic [4:0] a, input logic [15:0] e, input string nm);
      regAddr = a;
      @(negedge ref_clk);
      check(nm, e, regRdata);
   endtask : rd
   task automatic run_frames(input logic [15:0] k);
      logic [15:0] b;
      b = frames;
      while (frames - b < k)
         @(negedge ref_clk);
      @(negedge ref_clk);
   endtask : run_frames
   task automatic check_frame;
      int bad;
      logic [15:0] n;
      bad = 0;
      n = flen(sz);
      check("length", n, 16'(q.size()));
      check("dst", {8'hff, 4'hf, dst}, {q[4], q[5]});
      check("src", {8'hff, 4'hf, src}, {q[10], q[11]});
      check("lenfield", n - 16'h0012, {q[12], q[13]});
      for (int i = 14; i < n - 4; i++)
         if (typ != 2'h0 && q[i] !== (typ == 2'h1 ? 8'(i - 14) : pat))
            bad++;
      check("payload", 16'h0000, 16'(bad));
      check("fcs", 16'h0001, {15'h0000, crcOk});
      q.delete();
   endtask : check_frame
   always @(negedge ref_clk)
   begin
      cyc++;
      if (cyc > 60000)
      begin
         err_count++;
         report_and_stop();
      end
      if (pend)
         check_frame();
      pend = txLast;
      if (txFirst)
         lastGap = gap;
      gap = txValid ? 16'h0000 : gap + 16'h0001;
      if (txValid)
         q.push_back(txData);
      if (groupDone)
         nGroup++;
   end
   initial
   begin
      void'($urandom(3));
      repeat (16) @(negedge ref_clk);
      reset_n = 1'b1;
      @(negedge ref_clk);
      rd(TFS_CTRL_ADDR, 16'h0000, "ctrl rst");
      rd(TFS_PATTERN_ADDR, 16'h00aa, "pat rst");
      rd(5'h1e, 16'h0000, "unmapped");
      wr(TFS_CTRL_ADDR, 16'hfffc);
      rd(TFS_CTRL_ADDR, 16'h2f70, "ctrl mask");
      // a write while the clock enable is low must be lost
      clkEn = 1'b0;
      wr(TFS_CTRL_ADDR, 16'h0000);
      clkEn = 1'b1;
      rd(TFS_CTRL_ADDR, 16'h2f70, "frozen");
      wr(TFS_CTRL_ADDR, 16'h0002);
      repeat (100) @(negedge ref_clk);
      check("no frame", 16'h0000, frames);
      for (int s = 0; s < 7; s++)
      begin
         {dst, src, pat} = 16'($urandom());
         typ = s[0] ? 2'h1 : 2'(s / 2 + 2);
         sz = 3'(s);
         w = {4'h2, 2'h0, typ, 1'b0, sz, 4'h3};
         wr(TFS_PATTERN_ADDR, {dst, src, pat});
         wr(TFS_CTRL_ADDR, w);
         run_frames(16'h0001);
         repeat (20) @(negedge ref_clk);
         rd(TFS_CTRL_ADDR, w & 16'hfffd, "start clr");
         check("single", 16'(s + 1), frames);
      end
      for (int g = 0; g < 4; g++)
      begin
         typ = 2'h2;
         sz = 3'h0;
         nGroup = 16'h0000;
         wr(TFS_CTRL_ADDR, {4'h0, 2'(g), 2'h2, 8'h03});
         run_frames(16'h0003);
         check("gap", g == 0 ? 16'h0006 : g == 1 ? 16'h000c : 16'h04b0, lastGap);
         check("group", 16'h0001, nGroup);
         wr(TFS_CTRL_ADDR, 16'h0001);
         repeat (1300) @(negedge ref_clk);
         f0 = frames;
         repeat (1300) @(negedge ref_clk);
         check("halt", f0, frames);
      end
      report_and_stop();
   end
endmodule : test_tfs_test_frame_source

// ---- tb/tfs_checker_sva.sv ----
// assertions on the frame stream ports
module tfs_checker_sva
   import tfs_pkg::*;
#(
   parameter logic [23:0] PREFIX_CODE = 24'h02a5c3 // arbitrary value
)
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [7:0] txData,
   input wire logic txValid,
   input wire logic txFirst,
   input wire logic txLast,
   input wire logic groupDone
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);
   // both addresses share the prefix, only the low nibble differs
   sequence addr_head;
      txData == PREFIX_CODE[23:16] ##1 txData == PREFIX_CODE[15:8]
         ##1 txData == PREFIX_CODE[7:0] ##1 (txData == 8'hff) [*2] ##1 txData[7:4] == 4'hf;
   endsequence
   sequence quiet_gap;
      !txValid [*6];
   endsequence
   a_dst_prefix: assert property (txFirst |-> addr_head)
      else $error("bad destination");
   a_src_prefix: assert property (txFirst |-> ##6 addr_head)
      else $error("bad source");
   a_gap_quiet: assert property (txLast |=> quiet_gap)
      else $error("gap short");
   a_rise_first: assert property ($rose(txValid) |-> txFirst)
      else $error("no first byte");
   a_fell_last: assert property ($fell(txValid) |-> $past(txLast))
      else $error("frame cut");
   a_min_len: assert property (txFirst |-> (txValid && !txLast) [*8])
      else $error("frame short");
   a_group_last: assert property (groupDone |-> txLast)
      else $error("group misplaced");
   a_last_valid: assert property (txLast |-> txValid && !txFirst)
      else $error("last outside frame");
endmodule : tfs_checker_sva
bind tfs_test_frame_source tfs_checker_sva #(.PREFIX_CODE(PREFIX_CODE)) chk (
   .ref_clk(ref_clk), .reset_n(reset_n), .txData(txData), .txValid(txValid),
   .txFirst(txFirst), .txLast(txLast), .groupDone(groupDone));

// ---- tb/tfs_tx_sink.sv ----
// frame sink: fcs residue check and frame count
module tfs_tx_sink
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [7:0] txData,
   input wire logic txValid,
   input wire logic txFirst,
   input wire logic txLast,
   output logic crcOk,
   output logic [15:0] frames
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] crc;
   function automatic logic [31:0] step(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c ^ {24'h000000, d};
      for (int i = 0; i < 8; i++)
         r = r[0] ? (r >> 1) ^ 32'hedb88320 : r >> 1;
      return r;
   endfunction : step
   // a good frame leaves a fixed residue once its fcs is folded in
   assign crcOk = crc === 32'hdebb20e3;
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         crc <= 32'hffffffff;
         frames <= 16'h0000;
      end
      else if (txValid)
      begin
         crc <= step(txFirst ? 32'hffffffff : crc, txData);
         frames <= frames + {15'h0000, txLast};
      end
   end
endmodule : tfs_tx_sink
